// File: rtl/ismsv_pkg.sv
/*
 * package for the isolated supply mode supervisor: mode codes, soft-start
 * timing, APB register map, field positions and reset values.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ismsv_pkg;

	// =====================================================================
	// modes
	typedef enum logic [2:0] {
		MODE_DISABLE  = 3'b000,
		MODE_SOFTSTRT = 3'b001,
		MODE_NORMAL   = 3'b010,
		MODE_AUTOREC  = 3'b011,
		MODE_LATCHED  = 3'b100
	} ismsv_mode_t;

	// =====================================================================
	// timing
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned SS_TIME_US    = 1000;
	localparam int unsigned SS_CYCLES     = (CLK_HZ / 1000000) * SS_TIME_US;
	localparam int unsigned RAMP_W        = 8;
	localparam logic [RAMP_W-1:0] RAMP_MAX = 8'hFF;

	// =====================================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MK = 8'h0C;

	// ctrl fields
	localparam int unsigned CTRL_SS_BYPASS = 0;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

	// irq bits
	localparam int unsigned IRQ_W          = 4;
	localparam int unsigned IRQ_NORMAL     = 0;
	localparam int unsigned IRQ_LATCH      = 1;
	localparam int unsigned IRQ_LOCKOUT    = 2;
	localparam int unsigned IRQ_OUT_UV     = 3;
	localparam logic [IRQ_W-1:0] IRQ_MK_RST = 4'h0;

	// status fields
	localparam int unsigned ST_MODE_LSB    = 0;
	localparam int unsigned ST_RAMP_LSB    = 8;
	localparam int unsigned ST_MODE_W      = 3;
	localparam int unsigned ST_LATCH_POS   = 3;

endpackage

// File: rtl/ismsv_sync.sv
/*
 * two-flop synchroniser for a bus of level flags.
 * assumes the inputs are slow levels; multi-bit skew is harmless because
 * each flag is consumed independently.
 */
`timescale 1ns/10ps
`default_nettype none
module ismsv_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk, // clock
	input  wire logic         rstn,    // async reset, active low
	input  wire logic [W-1:0] async_i, // asynchronous levels
	output logic      [W-1:0] sync_o   // synchronised levels
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule
`default_nettype wire

// File: rtl/ismsv_top.sv
/*
 * mode supervisor of an isolated power module: picks one of five modes from
 * the lockout flags, the enable pin and the fault flags, gates switching,
 * ramps soft-start and drives the open-drain power-good pin; APB registers.
 * assumes lockout and fault flags come from analog comparators (async).
 */
// Chosen here: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module ismsv_top
	import ismsv_pkg::*;
#(
	parameter int unsigned SS_CNT = SS_CYCLES
) (
	input  wire logic        ref_clk,         // 40 MHz clock
	input  wire logic        rstn,            // async reset, active low
	input  wire logic        converter_enable_input, // enable pin level
	input  wire logic        input_undervoltage_lockout, // supply below rising level
	input  wire logic        input_overvoltage_lockout,  // supply above overvoltage level
	input  wire logic        analog_uv_reset, // supply below analog falling level
	input  wire logic        fault_other,     // any latching fault (ovp, otp...)
	input  wire logic        out_recovered,   // both outputs above recovery level
	output logic             switch_en,       // converter switching gate
	output logic [RAMP_W-1:0] ramp_level,     // soft-start duty/reference ramp
	output logic             power_good_n_o,  // power-good pin drive value (0)
	output logic             power_good_n_oe_n, // power-good enable, low drives
	output logic             irq,             // interrupt, active high
	input  wire logic [31:0] paddr,           // apb address
	input  wire logic        psel,            // apb select
	input  wire logic        penable,         // apb enable
	input  wire logic        pwrite,          // apb direction
	input  wire logic [31:0] pwdata,          // apb write data
	output logic [31:0]      prdata,          // apb read data
	output logic             pready,          // apb ready
	output logic             pslverr          // apb error
);
	// =====================================================================
	// input synchronisation
	logic [5:0] raw_in;
	logic [5:0] syn_in;
	logic       en_s, lo_uv_s, lo_ov_s, auv_s, flt_s, rec_s;

	assign raw_in = {converter_enable_input, input_undervoltage_lockout,
		input_overvoltage_lockout, analog_uv_reset, fault_other, out_recovered};

	ismsv_sync #(.W(6)) u_sync (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.async_i (raw_in),
		.sync_o  (syn_in)
	);

	// an undriven enable reads low here via the pull-down; nothing else
	assign {en_s, lo_uv_s, lo_ov_s, auv_s, flt_s, rec_s} = syn_in;

	// =====================================================================
	// mode state
	ismsv_mode_t       mode_q, mode_d;
	logic              latch_q, latch_d;
	logic              en_prev_q, en_prev_d;
	logic [31:0]       ss_cnt_q, ss_cnt_d;
	logic [RAMP_W-1:0] ramp_q, ramp_d;
	logic              uv_evt;
	logic              ss_bypass;
	logic              lockout;
	logic              en_fall;

	assign lockout = lo_uv_s | lo_ov_s;
	assign en_fall = en_prev_q & ~en_s;

	always_comb begin
		mode_d    = mode_q;
		latch_d   = latch_q;
		en_prev_d = en_s;
		ss_cnt_d  = ss_cnt_q;
		ramp_d    = ramp_q;
		uv_evt    = 1'b0;
		// latch survives overvoltage lockout; only an analog dip or a falling enable edge clears it
		if (auv_s || en_fall) begin
			latch_d = 1'b0;
		end
		unique case (mode_q)
			MODE_DISABLE: begin
				ramp_d   = '0;
				ss_cnt_d = '0;
				if (en_s) begin
					mode_d = MODE_SOFTSTRT;
				end
			end
			MODE_SOFTSTRT: begin
				// undervoltage check ignored while ramping
				ss_cnt_d = ss_cnt_q + 32'h0000_0001;
				if (ramp_q != RAMP_MAX) begin
					ramp_d = ramp_q + {{(RAMP_W-1){1'b0}}, 1'b1};
				end
				if (!en_s) begin
					mode_d = MODE_DISABLE;
				end else if (ss_bypass || ss_cnt_q >= SS_CNT - 1) begin
					if (!rec_s) begin
						uv_evt  = 1'b1;
						latch_d = 1'b1;
						mode_d  = MODE_LATCHED;
					end else begin
						ramp_d = RAMP_MAX;
						mode_d = MODE_NORMAL;
					end
				end
			end
			MODE_NORMAL: begin
				if (!en_s) begin
					mode_d = MODE_DISABLE;
				end else if (!rec_s) begin
					uv_evt  = 1'b1;
					latch_d = 1'b1;
					mode_d  = MODE_LATCHED;
				end
			end
			MODE_AUTOREC: begin
				ramp_d   = '0;
				ss_cnt_d = '0;
				if (!lockout) begin
					if (latch_d) begin
						mode_d = MODE_LATCHED;
					end else if (en_s) begin
						mode_d = MODE_SOFTSTRT;
					end else begin
						mode_d = MODE_DISABLE;
					end
				end
			end
			MODE_LATCHED: begin
				ramp_d   = '0;
				ss_cnt_d = '0;
				if (!latch_d && !flt_s) begin
					mode_d = en_s ? MODE_SOFTSTRT : MODE_DISABLE;
				end
			end
			default: begin
				mode_d = MODE_AUTOREC;
			end
		endcase
		if (flt_s && mode_q != MODE_AUTOREC) begin
			latch_d = 1'b1;
			mode_d  = MODE_LATCHED;
		end
		if (lockout) begin
			mode_d = MODE_AUTOREC;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_q    <= MODE_AUTOREC;
			latch_q   <= 1'b0;
			en_prev_q <= 1'b0;
			ss_cnt_q  <= '0;
			ramp_q    <= '0;
		end else begin
			mode_q    <= mode_d;
			latch_q   <= latch_d;
			en_prev_q <= en_prev_d;
			ss_cnt_q  <= ss_cnt_d;
			ramp_q    <= ramp_d;
		end
	end

	// =====================================================================
	// pin outputs; switching gate and power-good enable registered from the next mode
	logic sw_q, sw_d;
	logic good_oe_n_q, good_oe_n_d;

	always_comb begin
		sw_d        = (mode_d == MODE_SOFTSTRT) || (mode_d == MODE_NORMAL);
		good_oe_n_d = (mode_d != MODE_NORMAL);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sw_q        <= 1'b0;
			good_oe_n_q <= 1'b1;
		end else begin
			sw_q        <= sw_d;
			good_oe_n_q <= good_oe_n_d;
		end
	end

	assign switch_en         = sw_q;
	assign ramp_level        = ramp_q;
	assign power_good_n_o    = 1'b0;
	assign power_good_n_oe_n = good_oe_n_q;

	// =====================================================================
	// apb slave and interrupts
	logic [31:0]      ctrl_q, ctrl_d;
	logic [IRQ_W-1:0] ist_q, ist_d;
	logic [IRQ_W-1:0] imk_q, imk_d;
	logic [31:0]      rd_q, rd_d;
	logic             rdy_q, rdy_d;
	logic             err_q, err_d;
	logic             irq_q, irq_d;
	logic [IRQ_W-1:0] evt;
	logic             acc;
	logic             wr;

	assign ss_bypass = ctrl_q[CTRL_SS_BYPASS];
	assign acc = psel & penable & ~rdy_q;
	assign wr  = acc & pwrite;

	always_comb begin
		evt             = '0;
		evt[IRQ_NORMAL] = (mode_d == MODE_NORMAL) && (mode_q != MODE_NORMAL);
		evt[IRQ_LATCH]  = (mode_d == MODE_LATCHED) && (mode_q != MODE_LATCHED);
		evt[IRQ_LOCKOUT] = (mode_d == MODE_AUTOREC) && (mode_q != MODE_AUTOREC);
		evt[IRQ_OUT_UV] = uv_evt;
		ctrl_d = ctrl_q;
		imk_d  = imk_q;
		ist_d  = ist_q;
		rd_d   = '0;
		err_d  = 1'b0;
		rdy_d  = acc;
		if (wr && paddr[7:0] == ADDR_IRQ_ST) begin
			ist_d = ist_q & ~pwdata[IRQ_W-1:0];
		end
		ist_d = ist_d | evt; // set wins over clear
		if (acc) begin
			unique case (paddr[7:0])
				ADDR_CTRL: begin
					rd_d = ctrl_q;
					if (pwrite) ctrl_d = pwdata;
				end
				ADDR_STATUS: begin
					rd_d = '0;
					rd_d[ST_MODE_LSB +: ST_MODE_W] = mode_q;
					rd_d[ST_LATCH_POS]             = latch_q;
					rd_d[ST_RAMP_LSB +: RAMP_W] = ramp_q;
				end
				ADDR_IRQ_ST: rd_d = {{(32-IRQ_W){1'b0}}, ist_q};
				ADDR_IRQ_MK: begin
					rd_d = {{(32-IRQ_W){1'b0}}, imk_q};
					if (pwrite) imk_d = pwdata[IRQ_W-1:0];
				end
				default: err_d = 1'b1;
			endcase
		end
		irq_d = |(ist_d & imk_d);
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST;
			ist_q  <= '0;
			imk_q  <= IRQ_MK_RST;
			rd_q   <= '0;
			rdy_q  <= 1'b0;
			err_q  <= 1'b0;
			irq_q  <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ist_q  <= ist_d;
			imk_q  <= imk_d;
			rd_q   <= rd_d;
			rdy_q  <= rdy_d;
			err_q  <= err_d;
			irq_q  <= irq_d;
		end
	end

	assign prdata  = rd_q;
	assign pready  = rdy_q;
	assign pslverr = err_q;
	assign irq     = irq_q;

	// =====================================================================
	// checks
	property p_lock;
		@(posedge ref_clk) disable iff (!rstn) lockout |=> mode_q == MODE_AUTOREC;
	endproperty
	a_lock: assert property (p_lock) else $error("lockout not auto-recovery");
	// pin drive registers on the same edge as the mode, so compare in one cycle
	property p_good;
		@(posedge ref_clk) disable iff (!rstn)
			power_good_n_oe_n == (mode_q != MODE_NORMAL);
	endproperty
	a_good: assert property (p_good) else $error("power-good drive not tied to normal");
	property p_dis;
		@(posedge ref_clk) disable iff (!rstn) (mode_q == MODE_DISABLE) |-> !switch_en;
	endproperty
	a_dis: assert property (p_dis) else $error("switching in disable");
	property p_stay;
		@(posedge ref_clk) disable iff (!rstn)
			(mode_q == MODE_LATCHED && !auv_s && !en_fall && latch_q && !lockout)
			|=> mode_q == MODE_LATCHED;
	endproperty
	a_stay: assert property (p_stay) else $error("latch left without reset");
	property p_flt;
		@(posedge ref_clk) disable iff (!rstn)
			(flt_s && !lockout && mode_q != MODE_AUTOREC) |=> mode_q == MODE_LATCHED;
	endproperty
	a_flt: assert property (p_flt) else $error("fault did not latch");
	property p_ss;
		@(posedge ref_clk) disable iff (!rstn)
			(mode_q != MODE_SOFTSTRT && mode_q != MODE_NORMAL)
			|=> mode_q != MODE_NORMAL;
	endproperty
	a_ss: assert property (p_ss) else $error("normal without soft-start");
	property p_ovl;
		@(posedge ref_clk) disable iff (!rstn)
			(mode_q == MODE_AUTOREC && latch_q && !auv_s && !en_fall)
			|=> latch_q;
	endproperty
	a_ovl: assert property (p_ovl) else $error("lockout cleared latch");
	property p_en;
		@(posedge ref_clk) disable iff (!rstn) en_fall |=> !latch_q || $past(flt_s);
	endproperty
	a_en: assert property (p_en) else $error("enable toggle kept latch");
	property p_auv;
		@(posedge ref_clk) disable iff (!rstn)
			(auv_s && !flt_s && mode_q != MODE_SOFTSTRT && mode_q != MODE_NORMAL)
			|=> !latch_q;
	endproperty
	a_auv: assert property (p_auv) else $error("analog dip kept latch");
endmodule
`default_nettype wire

// File: dv/ismsv_ctrl_model.sv
/*
 * behavioural system controller: drives the enable pin and resolves power-good.
 * assumes power-good has a board pull-up and enable is driven at all times.
 */
`timescale 1ns/10ps
`default_nettype none
module ismsv_ctrl_model (
	input  wire logic ref_clk,                // clock
	input  wire logic en_cmd,                 // requested enable level
	input  wire logic power_good_n_o,         // pin drive value
	input  wire logic power_good_n_oe_n,      // pin enable, low drives
	output var  logic converter_enable_input, // enable pin
	output logic      pwr_good_n              // resolved pin level
);
	// =====================================================================
	// enable drive
	// never left floating, so the weak pull-down is never relied upon
	initial begin
		converter_enable_input = 1'b0;
		forever @(posedge ref_clk) converter_enable_input <= en_cmd;
	end
	// =====================================================================
	// open-drain pin: released reads as the pull-up level
	assign pwr_good_n = power_good_n_oe_n ? 1'b1 : power_good_n_o;
endmodule
`default_nettype wire

// File: dv/ismsv_tb.sv
/*
 * self-checking bench for the mode supervisor, apb tasks and mode walks.
 * assumes the controller model and the design package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ismsv_pkg::*;
	localparam int unsigned SS_N = 20;
	logic        ref_clk, rstn, en_cmd, en_pin, lo_uv, lo_ov, dip, flt, orec;
	logic        psel, penable, pwrite, pready, pslverr, err, irq, switch_en;
	logic        good_drv, good_oe_n, pwr_good_n;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [7:0]  ramp_level;
	int          fails, checks;

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	ismsv_top #(.SS_CNT(SS_N)) uut (.ref_clk(ref_clk), .rstn(rstn),
		.converter_enable_input(en_pin), .input_undervoltage_lockout(lo_uv),
		.input_overvoltage_lockout(lo_ov), .analog_uv_reset(dip), .fault_other(flt),
		.out_recovered(orec), .switch_en(switch_en), .ramp_level(ramp_level),
		.power_good_n_o(good_drv), .power_good_n_oe_n(good_oe_n), .irq(irq),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	ismsv_ctrl_model ctrl (.ref_clk(ref_clk), .en_cmd(en_cmd),
		.power_good_n_o(good_drv), .power_good_n_oe_n(good_oe_n),
		.converter_enable_input(en_pin), .pwr_good_n(pwr_good_n));

	// =====================================================================
	// compare and report
	task automatic chk1(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic chkw(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// =====================================================================
	// apb master: request held until pready is seen at a rising edge; only the
	// watchdog ends a hang, so no cycle count is assumed here
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// polls status until the mode shows, then checks the pins
	task automatic see_mode(input ismsv_mode_t m, input logic sw, input logic gn);
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
			if (rd[2:0] === m) break;
		end
		chkw({29'h0, rd[2:0]}, {29'h0, m}, "mode");
		chk1(switch_en, sw, "switching gate");
		chk1(pwr_good_n, gn, "power good pin");
	endtask

	initial begin
		#(25 * 20000);
		fails++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		stop_test();
	end

	initial begin
		fails = 0;
		checks = 0;
		{rstn, en_cmd, lo_ov, dip, flt, orec, psel, penable, pwrite} = 9'h0;
		lo_uv = 1'b1;
		paddr = 32'h0;
		pwdata = 32'h0;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		see_mode(MODE_AUTOREC, 1'b0, 1'b1);
		apb(1'b0, {24'h0, ADDR_IRQ_MK}, 32'h0);
		chkw(rd, {28'h0, IRQ_MK_RST}, "mask reset");
		apb(1'b0, {24'h0, ADDR_CTRL}, 32'h0);
		chkw(rd, CTRL_RST, "ctrl reset");
		chk1(err, 1'b0, "mapped accepted");
		apb(1'b0, 32'h0000_0010, 32'h0);
		chk1(err, 1'b1, "unmapped refused");
		apb(1'b1, {24'h0, ADDR_IRQ_MK}, 32'h0000_0002);
		$display("test reset done");
		@(posedge ref_clk);
		lo_uv <= 1'b0;
		see_mode(MODE_DISABLE, 1'b0, 1'b1);
		@(posedge ref_clk);
		en_cmd <= 1'b1;
		see_mode(MODE_SOFTSTRT, 1'b1, 1'b1);
		chk1(ramp_level > 8'h00 && ramp_level < RAMP_MAX, 1'b1, "ramp");
		orec <= 1'b1;
		see_mode(MODE_NORMAL, 1'b1, 1'b0);
		chkw({24'h0, ramp_level}, {24'h0, RAMP_MAX}, "ramp top");
		$display("test startup done");
		flt <= 1'b1;
		see_mode(MODE_LATCHED, 1'b0, 1'b1);
		repeat (2) @(negedge ref_clk);
		chk1(irq, 1'b1, "irq raised");
		apb(1'b1, {24'h0, ADDR_IRQ_ST}, 32'h0000_000F);
		repeat (2) @(negedge ref_clk);
		chk1(irq, 1'b0, "irq cleared");
		@(posedge ref_clk);
		flt <= 1'b0;
		repeat (10) @(posedge ref_clk);
		see_mode(MODE_LATCHED, 1'b0, 1'b1);
		lo_ov <= 1'b1;
		see_mode(MODE_AUTOREC, 1'b0, 1'b1);
		chk1(rd[3], 1'b1, "latch kept in lockout");
		lo_ov <= 1'b0;
		see_mode(MODE_LATCHED, 1'b0, 1'b1);
		$display("test latch done");
		en_cmd <= 1'b0;
		repeat (8) @(posedge ref_clk);
		en_cmd <= 1'b1;
		see_mode(MODE_SOFTSTRT, 1'b1, 1'b1);
		see_mode(MODE_NORMAL, 1'b1, 1'b0);
		orec <= 1'b0;
		see_mode(MODE_LATCHED, 1'b0, 1'b1);
		$display("test enable toggle done");
		lo_uv <= 1'b1;
		dip <= 1'b1;
		see_mode(MODE_AUTOREC, 1'b0, 1'b1);
		dip <= 1'b0;
		lo_uv <= 1'b0;
		see_mode(MODE_SOFTSTRT, 1'b1, 1'b1);
		see_mode(MODE_LATCHED, 1'b0, 1'b1);
		$display("test supply dip done");
		// bypass set: soft-start ends after one cycle, long before the counter would
		apb(1'b1, {24'h0, ADDR_CTRL}, 32'h0000_0001);
		orec <= 1'b1;
		en_cmd <= 1'b0;
		repeat (6) @(posedge ref_clk);
		en_cmd <= 1'b1;
		repeat (6) @(posedge ref_clk);
		apb(1'b0, {24'h0, ADDR_STATUS}, 32'h0);
		chkw({29'h0, rd[2:0]}, {29'h0, MODE_NORMAL}, "bypassed soft-start");
		$display("test bypass done");
		stop_test();
	end
endmodule
`default_nettype wire
